// File: ffm_cfg.svh
// Constants for the FIFO fault and device state manager.
// Assumes inclusion by bare name from the package and the design module.
`ifndef FFM_CFG_SVH
`define FFM_CFG_SVH
`define FFM_RX_FULL_COUNT      9'h0_0ff
`define FFM_TX_FULL_COUNT      10'h0_1ff
`define FFM_CHK_HEAD_VSYNC     16'haaf0
`define FFM_CHK_HEAD_LO        16'haa00
`define FFM_CHK_HEAD_HI        16'haa0f
`define FFM_OTP_CRC_POLY       8'h07
`define FFM_OTP_CRC_INIT       8'h00
`define FFM_OTP_BYTES          16'h0_010
`endif

// File: ffm_pkg.sv
// Types for the FIFO fault and device state manager.
// Assumes ffm_cfg.svh sits in the same folder.
`include "ffm_cfg.svh"
package ffm_pkg;
	// Device operating states
	typedef enum logic [1:0]
	{
		ST_UNPOWERED,
		ST_INIT,
		ST_NORMAL,
		ST_FAILSAFE
	} ffm_state_type;

	// Latched diagnostic flags
	typedef struct packed
	{
		logic tx_fifo_parity_flag;
		logic tx_fifo_overflow_flag;
		logic tx_fifo_underflow_flag;
		logic tx_fifo_group_flag;
		logic rx_fifo_overflow_flag;
		logic rx_fifo_underflow_flag;
		logic rx_fifo_parity_flag;
		logic rx_fifo_group_flag;
		logic input_stuck_flag;
		logic check_bit_flag;
		logic chain_crc_flag;
		logic cmd_queue_overflow_flag;
		logic chain_group_flag;
		logic spi_crc_flag;
		logic reg_write_fail_flag;
		logic otp_crc_flag;
		logic power_on_flag;
	} ffm_flags_type;

	// Fault masks
	typedef struct packed
	{
		logic spi_crc_mask;
		logic input_stuck_mask;
		logic check_bit_mask;
		logic chain_crc_mask;
	} ffm_mask_type;

	// Single-cycle event reports from the surrounding logic
	typedef struct packed
	{
		logic tx_parity_err;
		logic tx_word_store;
		logic tx_underflow;
		logic rx_word_store;
		logic rx_word_req;
		logic rx_parity_err;
		logic rx_head_byte_fwd_rd;
		logic input_stuck;
		logic check_bit_err;
		logic chain_crc_done;
		logic chain_crc_match;
		logic queue_full_new_cmd;
		logic spi_crc_err;
		logic chain_ctrl_write;
		logic watchdog_overflow;
		logic soft_reset_cmd;
	} ffm_event_type;
endpackage

// File: ffm_manager.sv
// FIFO fault, OTP check and device state manager of a SPI to chain bridge.
// Assumes events are one-cycle pulses on clk; undervoltage comes from a pin.
// Notes on behaviour
// - TX parity error sets flags, halts transmit
// - After TX parity error refuse stores until clear
// - RX full store sets overflow, drops word
// - RX storing resumes at checked read head
// - RX empty read sets underflow, suspends storing
// - RX parity error sets flags only
// - Power-up CRC-8 over OTP bytes compared
// - OTP mismatch: sticky flag, stay in Initialization
// - Masks gate only summary and fault pin
// - Four mask bits: SPI CRC, stuck, check, chain CRC
// - Undervoltage: Unpowered, reset, power-on flag, fault low
// - Watchdog overflow in Normal enters Failsafe
// - Chain control write while busy: write-fail flag only
// - Chain CRC checked only for listed head words
// - TX full store: overflow, stop, count zero
// - Queue full new command: overflow, flush queue
// - Initialization: slow SPI, clock runs, load on match
// - Normal transmit waits for power-on flag clear
// - Force-failsafe bit enters Failsafe, self clears
// - Failsafe entry clears TX FIFO, discards forwards
// - Exit-failsafe bit or soft reset returns Normal
// - Clear bit clears all flags but OTP CRC
`timescale 1ns/1ps
`include "ffm_cfg.svh"
module ffm_manager
#(
	parameter int OTP_BYTES = `FFM_OTP_BYTES
)
(
	input  wire logic                  clk,
	input  wire logic                  rst,
	input  wire logic                  uvlo_pin,
	input  wire ffm_pkg::ffm_event_type ev,
	input  wire logic [15:0]           chain_head_word,
	input  wire logic [8:0]            rx_fifo_fill_count,
	input  wire logic [9:0]            tx_fifo_fill_count,
	input  wire logic                  chain_busy,
	input  wire ffm_pkg::ffm_mask_type mask,
	input  wire logic                  flag_clear_bit,
	input  wire logic                  force_failsafe_bit,
	input  wire logic                  exit_failsafe_bit,
	input  wire logic [7:0]            otp_byte,
	input  wire logic [7:0]            otp_stored_crc,
	output logic [7:0]                 otp_addr,
	output logic                       otp_load,
	output ffm_pkg::ffm_flags_type     flags,
	output logic                       summary_flag,
	output logic                       fault_out,
	output logic                       fault_oe_n,
	output logic [1:0]                 device_state_field,
	output logic                       tx_enable,
	output logic                       tx_halt,
	output logic                       tx_fifo_clear_bit,
	output logic                       tx_store_allow,
	output logic                       rx_store_allow,
	output logic                       spi_slow_mode,
	output logic                       spi_reset,
	output logic                       chain_ctrl_write_ok
);
	// Elaboration check on OTP size
	if (OTP_BYTES < 1 || OTP_BYTES > 255)
	begin : g_bad
		$error("OTP_BYTES out of range");
	end

	// Undervoltage synchroniser, three stages
	logic [2:0] uv_sync_reg;
	logic [2:0] uv_sync_next;
	logic       uv_reg;          // Filtered undervoltage level
	logic       uv_next;

	// Device state
	ffm_pkg::ffm_state_type state_reg;
	ffm_pkg::ffm_state_type state_next;
	ffm_pkg::ffm_flags_type flags_reg;
	ffm_pkg::ffm_flags_type flags_next;
	logic       rx_suspend_reg;  // RX storing blocked by flow fault
	logic       rx_suspend_next;
	logic [7:0] crc_reg;         // Running OTP CRC
	logic [7:0] crc_next;
	logic [7:0] addr_reg;        // OTP byte index
	logic [7:0] addr_next;
	logic       otp_done_reg;    // Walk finished, mismatch held
	logic       otp_done_next;
	logic       fs_entry_reg;    // One-cycle failsafe entry pulse
	logic       fs_entry_next;
	logic       halt_reg;        // Transmission halted
	logic       halt_next;
	logic       tx_clr_reg;      // TX FIFO clear pulse
	logic       tx_clr_next;
	logic       err_reg;         // Unmasked error summary
	logic       err_next;

	// CRC-8 step, polynomial x^8+x^2+x+1
	function automatic logic [7:0] crc8_step(input logic [7:0] c, input logic [7:0] d);
		logic [7:0] r;
		r = c ^ d;
		for (int i = 0; i < 8; i++)
		begin
			r = r[7] ? ((r << 1) ^ `FFM_OTP_CRC_POLY) : (r << 1);
		end
		return r;
	endfunction

	// Head word qualifies for chain integrity check
	logic head_checked;
	assign head_checked = (chain_head_word == `FFM_CHK_HEAD_VSYNC) ||
		((chain_head_word >= `FFM_CHK_HEAD_LO) && (chain_head_word <= `FFM_CHK_HEAD_HI));

	// Next-state logic for all control state
	always_comb
	begin
		uv_sync_next    = {uv_sync_reg[1:0], uvlo_pin};
		uv_next         = (uv_sync_reg[1] == uv_sync_reg[2]) ? uv_sync_reg[2] : uv_reg;
		state_next      = state_reg;
		flags_next      = flags_reg;
		rx_suspend_next = rx_suspend_reg;
		crc_next        = crc_reg;
		addr_next       = addr_reg;
		otp_done_next   = otp_done_reg;
		fs_entry_next   = 1'b0;
		halt_next       = halt_reg;
		tx_clr_next     = 1'b0;
		// Host clear first so same-cycle events win
		if (flag_clear_bit)
		begin
			flags_next              = '0;
			flags_next.otp_crc_flag = flags_reg.otp_crc_flag;
			halt_next               = 1'b0;
		end
		case (state_reg)
			ffm_pkg::ST_UNPOWERED:
			begin
				// Power returned: start the OTP walk
				state_next    = ffm_pkg::ST_INIT;
				crc_next      = `FFM_OTP_CRC_INIT;
				addr_next     = 8'h00;
				otp_done_next = 1'b0;
			end
			ffm_pkg::ST_INIT:
			begin
				if (!otp_done_reg)
				begin
					crc_next  = crc8_step(crc_reg, otp_byte);
					addr_next = addr_reg + 8'h01;
					if (addr_reg == 8'(OTP_BYTES - 1))
					begin
						otp_done_next = 1'b1;
						if (crc_next == otp_stored_crc)
							state_next = ffm_pkg::ST_NORMAL;
						else
							flags_next.otp_crc_flag = 1'b1;
					end
				end
			end
			ffm_pkg::ST_NORMAL:
			begin
				// Watchdog or forced entry to failsafe
				if (ev.watchdog_overflow || force_failsafe_bit)
				begin
					state_next    = ffm_pkg::ST_FAILSAFE;
					fs_entry_next = 1'b1;
				end
			end
			ffm_pkg::ST_FAILSAFE:
			begin
				if (exit_failsafe_bit || ev.soft_reset_cmd)
					state_next = ffm_pkg::ST_NORMAL;
			end
			default:
			begin
				state_next = ffm_pkg::ST_UNPOWERED;
			end
		endcase
		// TX FIFO parity error on read
		if (ev.tx_parity_err)
		begin
			flags_next.tx_fifo_parity_flag = 1'b1;
			flags_next.tx_fifo_group_flag  = 1'b1;
			halt_next                      = 1'b1;
		end
		// TX underflow halts transmission
		if (ev.tx_underflow)
		begin
			flags_next.tx_fifo_underflow_flag = 1'b1;
			flags_next.tx_fifo_group_flag     = 1'b1;
			halt_next                         = 1'b1;
		end
		// TX overflow on a forwarded word store
		if (ev.tx_word_store && tx_fifo_fill_count == `FFM_TX_FULL_COUNT && state_reg != ffm_pkg::ST_FAILSAFE)
		begin
			flags_next.tx_fifo_overflow_flag = 1'b1;
			flags_next.tx_fifo_group_flag    = 1'b1;
			halt_next                        = 1'b1;
			tx_clr_next                      = 1'b1;
		end
		// Command queue overflow flushes queue and FIFO
		if (ev.queue_full_new_cmd)
		begin
			flags_next.cmd_queue_overflow_flag = 1'b1;
			flags_next.chain_group_flag        = 1'b1;
			halt_next                          = 1'b1;
			tx_clr_next                        = 1'b1;
		end
		// RX overflow drops the word
		if (ev.rx_word_store && rx_fifo_fill_count == `FFM_RX_FULL_COUNT)
		begin
			flags_next.rx_fifo_overflow_flag = 1'b1;
			flags_next.rx_fifo_group_flag    = 1'b1;
			rx_suspend_next                  = 1'b1;
		end
		// RX underflow on a data read
		if (ev.rx_word_req && rx_fifo_fill_count == 9'h0_000)
		begin
			flags_next.rx_fifo_underflow_flag = 1'b1;
			flags_next.rx_fifo_group_flag     = 1'b1;
			rx_suspend_next                   = 1'b1;
		end
		// Storing resumes only at a checked-read head once flags clear
		if (rx_suspend_reg && !flags_reg.rx_fifo_overflow_flag &&
			!flags_reg.rx_fifo_underflow_flag && ev.rx_head_byte_fwd_rd)
			rx_suspend_next = 1'b0;
		// RX parity error: flags only
		if (ev.rx_parity_err)
		begin
			flags_next.rx_fifo_parity_flag = 1'b1;
			flags_next.rx_fifo_group_flag  = 1'b1;
		end
		// Chain faults, flags always set regardless of mask
		if (ev.input_stuck)
			flags_next.input_stuck_flag = 1'b1;
		if (ev.check_bit_err)
			flags_next.check_bit_flag = 1'b1;
		if (ev.chain_crc_done && head_checked && !ev.chain_crc_match)
			flags_next.chain_crc_flag = 1'b1;
		if (ev.input_stuck || ev.check_bit_err || (ev.chain_crc_done && head_checked && !ev.chain_crc_match))
			flags_next.chain_group_flag = 1'b1;
		if (ev.spi_crc_err)
			flags_next.spi_crc_flag = 1'b1;
		// Rejected chain control write
		if (ev.chain_ctrl_write && chain_busy)
			flags_next.reg_write_fail_flag = 1'b1;
		// Undervoltage overrides state, flags, RX suspend, halt and OTP done, not the clear pulses
		if (uv_reg)
		begin
			state_next               = ffm_pkg::ST_UNPOWERED;
			flags_next               = '0;
			flags_next.power_on_flag = 1'b1;
			rx_suspend_next          = 1'b0;
			halt_next                = 1'b0;
			otp_done_next            = 1'b0;
		end
		// Summary: masked sources excluded, write failure never counts
		err_next = flags_next.power_on_flag | flags_next.otp_crc_flag |
			flags_next.tx_fifo_group_flag | flags_next.rx_fifo_group_flag |
			flags_next.cmd_queue_overflow_flag |
			(flags_next.spi_crc_flag & ~mask.spi_crc_mask) |
			(flags_next.input_stuck_flag & ~mask.input_stuck_mask) |
			(flags_next.check_bit_flag & ~mask.check_bit_mask) |
			(flags_next.chain_crc_flag & ~mask.chain_crc_mask) |
			(state_next == ffm_pkg::ST_FAILSAFE);
	end

	// Register all control state
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			uv_sync_reg    <= 3'h0;
			uv_reg         <= 1'b0;
			state_reg      <= ffm_pkg::ST_UNPOWERED;
			flags_reg      <= '0;
			rx_suspend_reg <= 1'b0;
			crc_reg        <= 8'h00;
			addr_reg       <= 8'h00;
			otp_done_reg   <= 1'b0;
			fs_entry_reg   <= 1'b0;
			halt_reg       <= 1'b0;
			tx_clr_reg     <= 1'b0;
			err_reg        <= 1'b0;
		end
		else
		begin
			uv_sync_reg    <= uv_sync_next;
			uv_reg         <= uv_next;
			state_reg      <= state_next;
			flags_reg      <= flags_next;
			rx_suspend_reg <= rx_suspend_next;
			crc_reg        <= crc_next;
			addr_reg       <= addr_next;
			otp_done_reg   <= otp_done_next;
			fs_entry_reg   <= fs_entry_next;
			halt_reg       <= halt_next;
			tx_clr_reg     <= tx_clr_next;
			err_reg        <= err_next;
		end
	end

	// Outputs derived from registered state; write accept and RX store gate also use inputs
	assign flags               = flags_reg;
	assign summary_flag        = err_reg;
	assign fault_out           = 1'b0;
	assign fault_oe_n          = ~err_reg;
	assign device_state_field  = state_reg;
	assign otp_addr            = addr_reg;
	assign otp_load            = (state_reg == ffm_pkg::ST_NORMAL) && otp_done_reg;
	assign spi_slow_mode       = (state_reg == ffm_pkg::ST_INIT);
	assign spi_reset           = fs_entry_reg | (state_reg == ffm_pkg::ST_UNPOWERED);
	assign tx_fifo_clear_bit   = tx_clr_reg | fs_entry_reg;
	assign tx_halt             = halt_reg | (state_reg != ffm_pkg::ST_NORMAL);
	// Transmit needs Normal, power-on flag cleared, no halt, no pending TX FIFO or queue fault
	assign tx_enable           = (state_reg == ffm_pkg::ST_NORMAL) && !flags_reg.power_on_flag &&
		!halt_reg && !flags_reg.tx_fifo_group_flag && !flags_reg.cmd_queue_overflow_flag;
	// Forward data dropped in failsafe or after a TX fault
	assign tx_store_allow      = (state_reg == ffm_pkg::ST_NORMAL) &&
		!flags_reg.tx_fifo_group_flag && !flags_reg.cmd_queue_overflow_flag;
	assign rx_store_allow      = !rx_suspend_reg &&
		(rx_fifo_fill_count != `FFM_RX_FULL_COUNT);
	assign chain_ctrl_write_ok = ev.chain_ctrl_write && !chain_busy;
endmodule

// File: ffm_host.sv
// Host model that writes the self-clearing control bits of the manager.
// Assumes the bench calls its task; bits change only off the falling edge.
`timescale 1ns/1ps
module ffm_host
(
	input  wire logic clk,
	output logic      flag_clear_bit,
	output logic      force_failsafe_bit,
	output logic      exit_failsafe_bit
);
	// Control bits idle low from time zero
	initial
	begin
		flag_clear_bit = 1'b0;
		force_failsafe_bit = 1'b0;
		exit_failsafe_bit = 1'b0;
	end

	// One-cycle write; the bits clear themselves, so a level would be wrong
	task automatic write_bit(input int which);
		@(negedge clk);
		case (which)
			0: flag_clear_bit = 1'b1;
			1: force_failsafe_bit = 1'b1;
			default: exit_failsafe_bit = 1'b1;
		endcase
		@(negedge clk);
		{flag_clear_bit, force_failsafe_bit, exit_failsafe_bit} = 3'b000;
	endtask
endmodule

// File: ffm_manager_props.sv
// Port-level checks of the fault and state manager.
// Assumes a bind into ffm_manager; one clock, synchronous reset.
`timescale 1ns/1ps
module ffm_manager_props
#(
	parameter int OTP_BYTES = 16
)
(
	input wire logic                   clk,
	input wire logic                   rst,
	input wire ffm_pkg::ffm_event_type ev,
	input wire logic [15:0]            chain_head_word,
	input wire logic [8:0]             rx_fifo_fill_count,
	input wire logic                   chain_busy,
	input wire logic                   flag_clear_bit,
	input wire logic                   force_failsafe_bit,
	input wire logic                   exit_failsafe_bit,
	input wire ffm_pkg::ffm_flags_type flags,
	input wire logic                   summary_flag,
	input wire logic                   fault_out,
	input wire logic                   fault_oe_n,
	input wire logic [1:0]             device_state_field,
	input wire logic                   tx_halt,
	input wire logic                   tx_enable,
	input wire logic                   tx_store_allow,
	input wire logic                   rx_store_allow,
	input wire logic                   tx_fifo_clear_bit,
	input wire logic                   chain_ctrl_write_ok
);
	// Everything on the one clock, silent in reset
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	a_txpar_flags: assert property (ev.tx_parity_err |=> flags.tx_fifo_parity_flag
		&& flags.tx_fifo_group_flag && tx_halt) else $error("tx parity not flagged");
	a_txpar_refuse: assert property (flags.tx_fifo_parity_flag |-> !tx_store_allow
		&& !tx_enable) else $error("tx store open after parity error");
	a_rx_overflow: assert property (ev.rx_word_store && rx_fifo_fill_count == 9'h0ff
		|=> flags.rx_fifo_overflow_flag && flags.rx_fifo_group_flag) else $error("rx overflow missed");
	a_rx_underflow: assert property (ev.rx_word_req && rx_fifo_fill_count == 9'h000
		|=> flags.rx_fifo_underflow_flag && !rx_store_allow) else $error("rx underflow missed");
	a_otp_sticky: assert property (flag_clear_bit && flags.otp_crc_flag
		|=> flags.otp_crc_flag) else $error("otp flag cleared by host");
	a_pin_follows: assert property (fault_oe_n == !summary_flag && !fault_out
		&& !(fault_oe_n && (flags.power_on_flag || flags.otp_crc_flag || flags.tx_fifo_group_flag)))
		else $error("fault pin differs from summary");
	a_wdog_failsafe: assert property (ev.watchdog_overflow && device_state_field == 2'd2
		|=> device_state_field == 2'd3 && summary_flag) else $error("watchdog not to failsafe");
	a_regfail_only: assert property (ev.chain_ctrl_write && chain_busy
		|-> !chain_ctrl_write_ok ##1 flags.reg_write_fail_flag) else $error("busy write taken");
	a_force_failsafe_bit: assert property (force_failsafe_bit && device_state_field == 2'd2
		|=> device_state_field == 2'd3) else $error("force failsafe ignored");
	a_fs_entry_clear: assert property ((device_state_field == 2'd2 ##1 device_state_field == 2'd3)
		|-> ##[0:1] tx_fifo_clear_bit) else $error("no fifo clear on failsafe entry");
	a_exit_failsafe_bit: assert property (exit_failsafe_bit && device_state_field == 2'd3
		|=> device_state_field == 2'd2) else $error("exit failsafe ignored");
	a_chain_crc_hit: assert property (ev.chain_crc_done && !ev.chain_crc_match
		&& chain_head_word inside {[16'haa00:16'haa0f], 16'haaf0} |=> flags.chain_crc_flag)
		else $error("chain crc mismatch missed");
	a_clear_flags: assert property (flag_clear_bit && !ev.tx_parity_err
		|=> !flags.tx_fifo_parity_flag) else $error("clear bit ignored");
endmodule

// File: ffm_manager_test.sv
// Self-checking bench of the fault and state manager.
// Assumes ffm_pkg, ffm_host and ffm_manager_props are compiled first.
`timescale 1ns/1ps
module ffm_manager_test;
	logic                   clk = 1'b0;          // 40 MHz clock
	logic                   rst;                 // Held 10 cycles
	logic                   uvlo_pin;            // Supply starts below threshold
	ffm_pkg::ffm_event_type ev;                  // Event pulses
	logic [15:0]            chain_head_word;     // Head of checked command
	logic [8:0]             rx_fifo_fill_count;  // Receive fill level
	logic [9:0]             tx_fifo_fill_count;  // Transmit fill level
	logic                   chain_busy;          // Chain activity level
	ffm_pkg::ffm_mask_type  mask;                // Fault masks
	logic [7:0]             otp_stored_crc;      // Stored memory checksum
	logic                   flag_clear_bit, force_failsafe_bit, exit_failsafe_bit;
	logic [7:0]             otp_byte, otp_addr;
	ffm_pkg::ffm_flags_type flags;
	logic [1:0]             device_state_field;
	logic                   otp_load, summary_flag, fault_out, fault_oe_n, tx_enable, tx_halt;
	logic                   tx_fifo_clear_bit, tx_store_allow, rx_store_allow, spi_slow_mode;
	logic                   spi_reset, chain_ctrl_write_ok;
	int                     num_errors = 0;
	int                     total_checks = 0;
	int                     src [4] = '{3, 8, 7, 6}; // Event and flag bit per mask
	logic [15:0]            heads [4] = '{16'haa00, 16'haaf0, 16'haa10, 16'ha9ff};

	always #12.5 clk = ~clk;

	// Memory image is a simple function of the address
	assign otp_byte = {otp_addr[5:0], 2'b01} ^ 8'h5a;

	ffm_manager #(.OTP_BYTES(4)) DUT (.clk, .rst, .uvlo_pin, .ev, .chain_head_word,
		.rx_fifo_fill_count, .tx_fifo_fill_count, .chain_busy, .mask, .flag_clear_bit,
		.force_failsafe_bit, .exit_failsafe_bit, .otp_byte, .otp_stored_crc, .otp_addr,
		.otp_load, .flags, .summary_flag, .fault_out, .fault_oe_n, .device_state_field,
		.tx_enable, .tx_halt, .tx_fifo_clear_bit, .tx_store_allow, .rx_store_allow,
		.spi_slow_mode, .spi_reset, .chain_ctrl_write_ok);
	ffm_host HOST (.clk, .flag_clear_bit, .force_failsafe_bit, .exit_failsafe_bit);

	// Expected CRC-8, polynomial 0x07, seed zero
	function automatic logic [7:0] otp_crc(input int n);
		logic [7:0] c;
		c = 8'h00;
		for (int a = 0; a < n; a++)
		begin
			c ^= {a[5:0], 2'b01} ^ 8'h5a;
			for (int b = 0; b < 8; b++)
				c = c[7] ? {c[6:0], 1'b0} ^ 8'h07 : {c[6:0], 1'b0};
		end
		return c;
	endfunction

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// One-cycle event; flags are settled when this returns
	task automatic fire(input int k);
		@(negedge clk);
		ev[k] = 1'b1;
		@(negedge clk);
		ev = '0;
	endtask

	// Bounded wait for a state; running out ends the run
	task automatic wait_state(input logic [1:0] s);
		int n;
		n = 0;
		while (device_state_field !== s && n < 300)
		begin
			@(negedge clk);
			n++;
		end
		check(device_state_field, s);
		if (n >= 300)
			give_verdict();
	endtask

	task automatic give_verdict();
		$display("Checks %0d, errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// Main sequence; inputs start idle, supply low until power-up
	initial
	begin
		rst = 1'b1;
		uvlo_pin = 1'b1;
		ev = '0;
		chain_head_word = 16'h0000;
		rx_fifo_fill_count = 9'h010;
		tx_fifo_fill_count = 10'h010;
		chain_busy = 1'b0;
		mask = '0;
		otp_stored_crc = 8'h00;
		repeat (10) @(negedge clk);
		rst = 1'b0;
		otp_stored_crc = ~otp_crc(4);
		// Let the synchroniser see the low supply first
		repeat (8) @(negedge clk);
		wait_state(2'd0);
		check(flags.power_on_flag, 1'b1);
		uvlo_pin = 1'b0;
		wait_state(2'd1);
		check(spi_slow_mode, 1'b1);
		repeat (20) @(negedge clk);
		check({device_state_field, flags.otp_crc_flag, fault_oe_n}, 4'b0110);
		HOST.write_bit(0);
		check(flags.otp_crc_flag, 1'b1);
		otp_stored_crc = otp_crc(4);
		uvlo_pin = 1'b1;
		wait_state(2'd0);
		check({flags.power_on_flag, fault_oe_n}, 2'b10);
		uvlo_pin = 1'b0;
		wait_state(2'd2);
		check({otp_load, flags.otp_crc_flag, tx_enable}, 3'b100);
		check(otp_addr, 8'h04);
		HOST.write_bit(0);
		check({tx_enable, summary_flag, fault_oe_n}, 3'b101);
		fire(15);
		check({flags.tx_fifo_parity_flag, flags.tx_fifo_group_flag, summary_flag}, 3'b111);
		check({fault_oe_n, tx_halt, tx_enable, tx_store_allow}, 4'b0100);
		HOST.write_bit(0);
		check({flags, summary_flag, fault_oe_n, tx_store_allow}, {17'h0_0000, 3'b011});
		rx_fifo_fill_count = 9'h0ff;
		fire(12);
		check({flags.rx_fifo_overflow_flag, flags.rx_fifo_group_flag, rx_store_allow}, 3'b110);
		rx_fifo_fill_count = 9'h010;
		HOST.write_bit(0);
		check(rx_store_allow, 1'b0);
		fire(9);
		check(rx_store_allow, 1'b1);
		rx_fifo_fill_count = 9'h000;
		fire(11);
		check({flags.rx_fifo_underflow_flag, summary_flag, rx_store_allow}, 3'b110);
		HOST.write_bit(0);
		fire(9);
		fire(10);
		check({flags.rx_fifo_parity_flag, flags.rx_fifo_group_flag, device_state_field}, 4'b1110);
		HOST.write_bit(0);
		// Each maskable source, masked then unmasked; head word is a checked one
		chain_head_word = 16'haa00;
		for (int i = 0; i < 8; i++)
		begin
			mask = ffm_pkg::ffm_mask_type'(i < 4 ? 4'b1000 >> i : 4'b0000);
			fire(src[i % 4]);
			check({flags[src[i % 4]], summary_flag, fault_oe_n}, i < 4 ? 3'b101 : 3'b110);
			HOST.write_bit(0);
		end
		// Head words inside and outside the checked set
		for (int i = 0; i < 4; i++)
		begin
			chain_head_word = heads[i];
			fire(6);
			check(flags.chain_crc_flag, i < 2);
			HOST.write_bit(0);
		end
		tx_fifo_fill_count = 10'h1ff;
		fire(14);
		check({flags.tx_fifo_overflow_flag, flags.tx_fifo_group_flag, summary_flag, tx_halt}, 4'hf);
		HOST.write_bit(0);
		fire(4);
		check({flags.cmd_queue_overflow_flag, flags.chain_group_flag, tx_halt}, 3'b111);
		HOST.write_bit(0);
		chain_busy = 1'b1;
		fire(2);
		check({flags.reg_write_fail_flag, summary_flag, fault_oe_n}, 3'b101);
		chain_busy = 1'b0;
		// Idle chain: the write is taken in the same cycle
		@(negedge clk);
		ev.chain_ctrl_write = 1'b1;
		#1 check(chain_ctrl_write_ok, 1'b1);
		@(negedge clk);
		ev = '0;
		HOST.write_bit(0);
		HOST.write_bit(1);
		check({device_state_field, summary_flag, fault_oe_n}, 4'b1110);
		check({tx_fifo_clear_bit, spi_reset}, 2'b11);
		fire(14);
		check(flags.tx_fifo_overflow_flag, 1'b0);
		HOST.write_bit(2);
		check(device_state_field, 2'd2);
		fire(1);
		check({device_state_field, summary_flag, fault_oe_n}, 4'b1110);
		fire(0);
		check(device_state_field, 2'd2);
		give_verdict();
	end
endmodule

bind ffm_manager ffm_manager_props #(.OTP_BYTES(OTP_BYTES)) props_i (.clk, .rst, .ev,
	.chain_head_word, .rx_fifo_fill_count, .chain_busy, .flag_clear_bit, .force_failsafe_bit,
	.exit_failsafe_bit, .flags, .summary_flag, .fault_out, .fault_oe_n, .device_state_field,
	.tx_halt, .tx_enable, .tx_store_allow, .rx_store_allow, .tx_fifo_clear_bit,
	.chain_ctrl_write_ok);
